// file: gpms_pkg.sv
/*
 * Constants for the graphics power-management and software interrupt
 * register bank: offsets, field positions, reset values and encodings.
 * Assumes nothing of its surroundings.
 */
`default_nettype none
package gpms_pkg;

   // Configuration offsets, byte addresses
   localparam logic [7:0] GPMS_OFF_CAP_HEADER = 8'hd0;
   localparam logic [7:0] GPMS_OFF_CAPABILITIES = 8'hd2;
   localparam logic [7:0] GPMS_OFF_CTRL_STATUS = 8'hd4;
   localparam logic [7:0] GPMS_OFF_MAILBOX = 8'he0;

   // Capability header fields
   localparam logic [7:0] GPMS_CAPABILITY_IDENTIFIER = 8'h01;
   localparam logic [7:0] GPMS_NEXT_CAPABILITY_LINK = 8'h00;
   localparam logic [15:0] GPMS_CAP_HEADER_RESET = 16'h0001;

   // Capabilities register fields
   localparam int GPMS_CAP_WAKE_SUPPORT_LSB = 11;
   localparam int GPMS_CAP_D2_BIT = 10;
   localparam int GPMS_CAP_D1_BIT = 9;
   localparam int GPMS_CAP_DSI_BIT = 5;
   localparam int GPMS_CAP_AUX_POWER_BIT = 4;
   localparam int GPMS_CAP_WAKE_CLOCK_BIT = 3;
   localparam logic [2:0] GPMS_CAP_VERSION = 3'h1;
   localparam logic [15:0] GPMS_CAPABILITIES_RESET = 16'h0021;

   // Control/status fields
   localparam int GPMS_CS_WAKE_FLAG_BIT = 15;
   localparam int GPMS_CS_WAKE_ENABLE_BIT = 8;
   localparam int GPMS_CS_LEVEL_LSB = 0;
   localparam logic [15:0] GPMS_CTRL_STATUS_RESET = 16'h0000;

   // Mailbox fields
   localparam int GPMS_MB_TRIGGER_BIT = 0;
   localparam logic [15:0] GPMS_MAILBOX_RESET = 16'h0000;

   // Power levels held in the control/status field
   typedef enum logic [1:0] {
      GPMS_LEVEL_D0 = 2'b00,
      GPMS_LEVEL_D1 = 2'b01,
      GPMS_LEVEL_D2 = 2'b10,
      GPMS_LEVEL_D3 = 2'b11
   } gpms_level_e;

endpackage
`default_nettype wire

// file: gpms_regs.sv
/*
 * Power-management capability and software interrupt mailbox registers of
 * the integrated graphics unit, reached by configuration cycles.
 * Assumes a single clock, a synchronous active-high reset, and a
 * configuration and hub link agent on that same clock.
 */
// Overview of operation
// - Header low byte reads 01h, write-ignored
// - Header high byte link reads 00h
// - Wake support zero; wake pin never asserted
// - D2 and D1 support bits read zero
// - Device-specific initialisation bit reads one
// - Version reads 001b; bits 8:6 reserved
// - Aux power and wake clock read zero
// - Wake flag and enable hardwired zero
// - Data scale, selector and reserved read zero
// - Sleep level writable, reset D0, 11 D3
// - Unsupported level writes complete, are discarded
// - Mailbox bits 15:1 plain storage, reset zero
// - Trigger rising edge sends one message, merged if one is already pending
// - Trigger stays set until software clears
`timescale 1ns/1ps
`default_nettype none
module gpms_regs (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Configuration cycles, dword addressed with byte enables
   input wire logic cfg_req,
   input wire logic cfg_we,
   input wire logic [7:0] cfg_addr,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   output logic cfg_ack,
   output logic [31:0] cfg_rdata,
   // Hub link message
   output logic hub_link_smi_req,
   input wire logic hub_link_smi_ack,
   // Power state and wake pin
   output logic [1:0] device_sleep_level,
   output logic wake_event_n
);
   import gpms_pkg::*;

   gpms_smi_if smi ();

   logic [1:0] level_r;
   logic [1:0] level_nxt;
   logic [14:0] message_r;
   logic [14:0] message_nxt;
   logic trigger_r;
   logic trigger_nxt;
   logic trigger_pulse_r;
   logic ack_r;
   logic [31:0] rdata_r;
   logic wake_n_r;
   logic [31:0] rdata_nxt;
   logic wr_cap_dword;
   logic wr_cs_dword;
   logic wr_mb_dword;

   // Dword containing a byte offset
   function automatic logic [5:0] dword_of(input logic [7:0] offset);
      dword_of = offset[7:2];
   endfunction

   // Whether an access hits the dword holding the given offset
   function automatic logic hits(input logic [7:0] addr, input logic [7:0] offset);
      hits = (dword_of(addr) == dword_of(offset));
   endfunction

   // Byte lane merge of a 16-bit register from the low half of a write
   function automatic logic [15:0] merge16(input logic [15:0] old, input logic [15:0] wd,
                                           input logic [1:0] be);
      merge16 = old;
      if (be[0]) begin
         merge16[7:0] = wd[7:0];
      end
      if (be[1]) begin
         merge16[15:8] = wd[15:8];
      end
   endfunction

   // Only full-on and full-off levels may be entered
   function automatic logic level_supported(input logic [1:0] lvl);
      case (lvl)
         GPMS_LEVEL_D0: level_supported = 1'b1;
         GPMS_LEVEL_D3: level_supported = 1'b1;
         default: level_supported = 1'b0;
      endcase
   endfunction

   // Read images of the hardwired registers
   function automatic logic [15:0] cap_header_image();
      cap_header_image = {GPMS_NEXT_CAPABILITY_LINK, GPMS_CAPABILITY_IDENTIFIER};
   endfunction

   function automatic logic [15:0] capabilities_image();
      logic [15:0] v;
      v = 16'h0000;
      v[15:GPMS_CAP_WAKE_SUPPORT_LSB] = 5'h00;
      v[GPMS_CAP_D2_BIT] = 1'b0;
      v[GPMS_CAP_D1_BIT] = 1'b0;
      v[GPMS_CAP_DSI_BIT] = 1'b1;
      v[GPMS_CAP_AUX_POWER_BIT] = 1'b0;
      v[GPMS_CAP_WAKE_CLOCK_BIT] = 1'b0;
      v[2:0] = GPMS_CAP_VERSION;
      capabilities_image = v;
   endfunction

   function automatic logic [15:0] ctrl_status_image(input logic [1:0] lvl);
      logic [15:0] v;
      v = 16'h0000;
      v[GPMS_CS_WAKE_FLAG_BIT] = 1'b0;
      v[GPMS_CS_WAKE_ENABLE_BIT] = 1'b0;
      v[GPMS_CS_LEVEL_LSB +: 2] = lvl; // other bits stay zero
      ctrl_status_image = v;
   endfunction

   // Write decode
   assign wr_cap_dword = cfg_req && cfg_we && hits(cfg_addr, GPMS_OFF_CAP_HEADER);
   assign wr_cs_dword = cfg_req && cfg_we && hits(cfg_addr, GPMS_OFF_CTRL_STATUS);
   assign wr_mb_dword = cfg_req && cfg_we && hits(cfg_addr, GPMS_OFF_MAILBOX);

   // Power level next value; unsupported codes are dropped silently
   always_comb begin
      logic [15:0] merged;
      merged = merge16(ctrl_status_image(level_r), cfg_wdata[15:0], cfg_be[1:0]);
      level_nxt = level_r;
      if (wr_cs_dword && cfg_be[0] && level_supported(merged[GPMS_CS_LEVEL_LSB +: 2])) begin
         level_nxt = merged[GPMS_CS_LEVEL_LSB +: 2];
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         level_r <= GPMS_CTRL_STATUS_RESET[1:0];
      end else begin
         level_r <= level_nxt;
      end
   end

   // Mailbox next value
   always_comb begin
      logic [15:0] merged;
      merged = merge16({message_r, trigger_r}, cfg_wdata[15:0], cfg_be[1:0]);
      message_nxt = message_r;
      trigger_nxt = trigger_r;
      if (wr_mb_dword) begin
         message_nxt = merged[15:1];
         trigger_nxt = merged[GPMS_MB_TRIGGER_BIT]; // only software clears it
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         message_r <= GPMS_MAILBOX_RESET[15:1];
      end else begin
         message_r <= message_nxt;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         trigger_r <= GPMS_MAILBOX_RESET[0];
      end else begin
         trigger_r <= trigger_nxt;
      end
   end

   // One pulse per 0 to 1 transition, none when one is written over one
   always_ff @(posedge clk) begin
      if (rst) begin
         trigger_pulse_r <= 1'b0;
      end else begin
         trigger_pulse_r <= trigger_nxt && !trigger_r;
      end
   end

   assign smi.trigger = trigger_pulse_r;

   gpms_smi_sender u_sender (
      .clk(clk),
      .rst(rst),
      .smi(smi.sender),
      .hub_link_smi_req(hub_link_smi_req),
      .hub_link_smi_ack(hub_link_smi_ack)
   );

   // Read multiplexer; unmapped dwords read zero and writes there are lost
   always_comb begin
      rdata_nxt = 32'h0000_0000;
      if (hits(cfg_addr, GPMS_OFF_CAP_HEADER)) begin
         rdata_nxt = {capabilities_image(), cap_header_image()};
      end else if (hits(cfg_addr, GPMS_OFF_CTRL_STATUS)) begin
         rdata_nxt = {16'h0000, ctrl_status_image(level_r)};
      end else if (hits(cfg_addr, GPMS_OFF_MAILBOX)) begin
         rdata_nxt = {16'h0000, message_r, trigger_r};
      end
   end

   // Every cycle is answered one clock later, writes included
   always_ff @(posedge clk) begin
      if (rst) begin
         ack_r <= 1'b0;
      end else begin
         ack_r <= cfg_req;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         rdata_r <= 32'h0000_0000;
      end else if (cfg_req && !cfg_we) begin
         rdata_r <= rdata_nxt;
      end
   end

   // Wake pin is never driven active
   always_ff @(posedge clk) begin
      if (rst) begin
         wake_n_r <= 1'b1;
      end else begin
         wake_n_r <= 1'b1;
      end
   end

   // Writes to the read-only capability dword have no effect
   logic cap_write_seen;
   assign cap_write_seen = wr_cap_dword;

   assign cfg_ack = ack_r;
   assign cfg_rdata = rdata_r;
   assign device_sleep_level = level_r;
   assign wake_event_n = wake_n_r;
endmodule
`default_nettype wire

// file: gpms_regs_properties.sv
/*
 * Checker for the power-management and mailbox register bank.
 * Assumes it sees only the top module's ports, on one clock with a synchronous reset.
 */
`timescale 1ns/1ps
`default_nettype none
module gpms_regs_properties (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Configuration cycles
   input wire logic cfg_req,
   input wire logic cfg_we,
   input wire logic [7:0] cfg_addr,
   input wire logic [3:0] cfg_be,
   input wire logic [31:0] cfg_wdata,
   input wire logic cfg_ack,
   input wire logic [31:0] cfg_rdata,
   // Hub link and pins
   input wire logic hub_link_smi_req,
   input wire logic hub_link_smi_ack,
   input wire logic [1:0] device_sleep_level,
   input wire logic wake_event_n
);
   import gpms_pkg::*;
   logic [15:0] mb_r;
   logic [2:0] quiet_r;
   logic rd;
   logic wr_mb;
   logic wr_cs;
   logic set_b;
   assign rd = cfg_req && !cfg_we;
   assign wr_mb = cfg_req && cfg_we && cfg_addr[7:2] == GPMS_OFF_MAILBOX[7:2];
   assign wr_cs = cfg_req && cfg_we && cfg_addr[7:2] == GPMS_OFF_CTRL_STATUS[7:2] && cfg_be[0];
   assign set_b = wr_mb && cfg_be[0] && cfg_wdata[0];
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (rst);
   // Mailbox as software wrote it
   always_ff @(posedge clk) begin
      if (rst) begin
         mb_r <= 16'h0;
      end else if (wr_mb) begin
         mb_r[7:0] <= cfg_be[0] ? cfg_wdata[7:0] : mb_r[7:0];
         mb_r[15:8] <= cfg_be[1] ? cfg_wdata[15:8] : mb_r[15:8];
      end
   end
   // Cycles since the trigger last rose, saturating
   always_ff @(posedge clk) begin
      if (rst || (set_b && !mb_r[0])) begin
         quiet_r <= 3'h0;
      end else if (quiet_r != 3'h7) begin
         quiet_r <= quiet_r + 3'h1;
      end
   end
   sequence rise_s;
      set_b && !mb_r[0] && quiet_r == 3'h7 && !hub_link_smi_req;
   endsequence
   sequence msg_s;
      !hub_link_smi_req [*2] ##1 hub_link_smi_req;
   endsequence
   ack_pairs_a: assert property (cfg_ack == $past(cfg_req))
      else $error("ack does not follow request");
   wake_idle_a: assert property (wake_event_n)
      else $error("wake pin asserted");
   hdr_read_a: assert property (rd && cfg_addr[7:2] == 6'h34 |=> cfg_rdata == 32'h0021_0001)
      else $error("capability dword wrong");
   level_keep_a: assert property (wr_cs && cfg_wdata[1] != cfg_wdata[0] |=> $stable(device_sleep_level))
      else $error("unsupported level taken");
   level_set_a: assert property (wr_cs && cfg_wdata[1] == cfg_wdata[0] |=>
      device_sleep_level == $past(cfg_wdata[1:0]))
      else $error("level not written");
   mbox_read_a: assert property (rd && cfg_addr[7:2] == 6'h38 |=> cfg_rdata == {16'h0, mb_r})
      else $error("mailbox readback wrong");
   smi_start_a: assert property (rise_s |=> msg_s)
      else $error("message not raised");
   smi_hold_a: assert property (hub_link_smi_req && !hub_link_smi_ack |=> hub_link_smi_req)
      else $error("message dropped early");
   no_extra_a: assert property (set_b && mb_r[0] && quiet_r == 3'h7 && !hub_link_smi_req |=>
      !hub_link_smi_req [*4])
      else $error("extra message");
endmodule
`default_nettype wire

// file: gpms_regs_tb.sv
/*
 * Testbench for the register bank: reads, writes, sleep level and mailbox message.
 * Assumes the package, design and checker are compiled before it.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin bad_count++; \
   $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module gpms_regs_tb;
   import gpms_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic cfg_req = 1'b0;
   logic cfg_we = 1'b0;
   logic [7:0] cfg_addr = 8'h0;
   logic [3:0] cfg_be = 4'h0;
   logic [31:0] cfg_wdata = 32'h0;
   logic hub_link_smi_ack = 1'b0;
   logic cfg_ack;
   logic hub_link_smi_req;
   logic wake_event_n;
   logic [31:0] cfg_rdata;
   logic [31:0] rd;
   logic [1:0] device_sleep_level;
   int bad_count = 0;
   int n_tests = 0;
   gpms_regs uut (.clk(clk), .rst(rst), .cfg_req(cfg_req), .cfg_we(cfg_we), .cfg_addr(cfg_addr),
      .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
      .hub_link_smi_req(hub_link_smi_req), .hub_link_smi_ack(hub_link_smi_ack),
      .device_sleep_level(device_sleep_level), .wake_event_n(wake_event_n));
   initial begin
      forever #5 clk = ~clk;
   end
   task automatic conclude;
      $display("mismatches %0d comparisons %0d", bad_count, n_tests);
      if (bad_count == 0 && n_tests > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // One configuration cycle; the acknowledge stands for one cycle only, the read data until the next read
   task automatic acc(input logic we, input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      @(negedge clk);
      cfg_req = 1'b1;
      cfg_we = we;
      cfg_addr = a;
      cfg_wdata = d;
      cfg_be = be;
      @(negedge clk);
      cfg_req = 1'b0;
      `CHK("ack", 1'b1, cfg_ack)
      rd = cfg_rdata;
   endtask
   task automatic chk_rd(input logic [7:0] a, input logic [31:0] e);
      acc(1'b0, a, 32'h0, 4'hf);
      `CHK("rdata", e, rd)
   endtask
   task automatic wait_req(output int n);
      n = 0;
      while (hub_link_smi_req !== 1'b1 && n < 10) begin
         @(negedge clk);
         n++;
      end
      if (hub_link_smi_req !== 1'b1) begin
         bad_count++;
         conclude();
      end
   endtask
   task automatic t_reset;
      chk_rd(GPMS_OFF_CAP_HEADER, 32'h0021_0001);
      chk_rd(GPMS_OFF_CTRL_STATUS, 32'h0);
      chk_rd(GPMS_OFF_MAILBOX, 32'h0);
      `CHK("wake pin", 1'b1, wake_event_n)
   endtask
   task automatic t_readonly;
      acc(1'b1, GPMS_OFF_CAP_HEADER, 32'hffff_ffff, 4'hf);
      chk_rd(GPMS_OFF_CAP_HEADER, 32'h0021_0001);
      acc(1'b1, GPMS_OFF_CTRL_STATUS, 32'hffff_ffff, 4'hf);
      chk_rd(GPMS_OFF_CTRL_STATUS, 32'h3);
   endtask
   task automatic t_levels;
      logic [1:0] lv[6] = '{2'b01, 2'b10, 2'b00, 2'b10, 2'b01, 2'b11};
      logic [1:0] e;
      e = 2'b11;
      foreach (lv[i]) begin
         acc(1'b1, GPMS_OFF_CTRL_STATUS, {30'h0, lv[i]}, 4'h1);
         e = (lv[i][1] == lv[i][0]) ? lv[i] : e;
         `CHK("level", e, device_sleep_level)
         chk_rd(GPMS_OFF_CTRL_STATUS, {30'h0, e});
      end
   endtask
   task automatic t_mailbox;
      int n;
      acc(1'b1, GPMS_OFF_MAILBOX, 32'h0000_fffe, 4'h3);
      chk_rd(GPMS_OFF_MAILBOX, 32'h0000_fffe);
      `CHK("idle", 1'b0, hub_link_smi_req)
      acc(1'b1, GPMS_OFF_MAILBOX, 32'h0000_ffff, 4'h3);
      wait_req(n);
      `CHK("delay", 2, n)
      @(negedge clk);
      `CHK("held", 1'b1, hub_link_smi_req)
      hub_link_smi_ack = 1'b1;
      @(negedge clk);
      hub_link_smi_ack = 1'b0;
      `CHK("drop", 1'b0, hub_link_smi_req)
      chk_rd(GPMS_OFF_MAILBOX, 32'h0000_ffff);
      acc(1'b1, GPMS_OFF_MAILBOX, 32'h1, 4'h1);
      repeat (6) @(negedge clk);
      `CHK("no extra", 1'b0, hub_link_smi_req)
      acc(1'b1, GPMS_OFF_MAILBOX, 32'h0, 4'h1);
      chk_rd(GPMS_OFF_MAILBOX, 32'h0000_ff00);
      acc(1'b1, GPMS_OFF_MAILBOX, 32'h1, 4'h1);
      wait_req(n);
      `CHK("again", 2, n)
   endtask
   // Reset in mid-run with a message raised, level D3 and a loaded mailbox
   task automatic t_midreset;
      @(negedge clk);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      `CHK("rst level", 2'b00, device_sleep_level)
      `CHK("rst message", 1'b0, hub_link_smi_req)
      `CHK("rst rdata", 32'h0, cfg_rdata)
      `CHK("rst wake pin", 1'b1, wake_event_n)
      chk_rd(GPMS_OFF_CTRL_STATUS, 32'h0);
      chk_rd(GPMS_OFF_MAILBOX, 32'h0);
   endtask
   initial begin
      repeat (3) @(posedge clk);
      @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_readonly();
      t_levels();
      t_mailbox();
      t_midreset();
      conclude();
   end
endmodule
bind gpms_regs gpms_regs_properties chk (.clk(clk), .rst(rst), .cfg_req(cfg_req), .cfg_we(cfg_we),
   .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_ack(cfg_ack), .cfg_rdata(cfg_rdata),
   .hub_link_smi_req(hub_link_smi_req), .hub_link_smi_ack(hub_link_smi_ack),
   .device_sleep_level(device_sleep_level), .wake_event_n(wake_event_n));
`default_nettype wire

// file: gpms_smi_if.sv
/*
 * Carrier between the register bank and its interrupt message sender.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface gpms_smi_if;
   logic trigger;
   logic busy;

   modport bank (output trigger, input busy);
   modport sender (input trigger, output busy);
endinterface
`default_nettype wire

// file: gpms_smi_sender.sv
/*
 * Sends one system management interrupt message over the hub link for each
 * trigger pulse not merged into a pending one, by a request held until the hub link acknowledges it.
 * Assumes the hub link logic runs on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module gpms_smi_sender (
   // Clock and reset
   input wire logic clk,
   input wire logic rst,
   // Bank side
   gpms_smi_if.sender smi,
   // Hub link side
   output logic hub_link_smi_req,
   input wire logic hub_link_smi_ack
);
   logic pending_r;
   logic req_r;
   logic launch;
   logic done;

   assign launch = pending_r && !req_r;
   assign done = req_r && hub_link_smi_ack;

   // A trigger arriving while one is pending is merged, set wins over launch
   always_ff @(posedge clk) begin
      if (rst) begin
         pending_r <= 1'b0;
      end else begin
         pending_r <= (pending_r && !launch) || smi.trigger;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         req_r <= 1'b0;
      end else if (launch) begin
         req_r <= 1'b1;
      end else if (done) begin
         req_r <= 1'b0;
      end
   end

   assign hub_link_smi_req = req_r;
   assign smi.busy = pending_r || req_r;
endmodule
`default_nettype wire
